// ---- bench/ppm_pin_mux_chk.sv ----
/* Checker for ppm_pin_mux: mode writes, analog routing, sinks, divided outputs.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps

module ppm_pin_mux_chk (
	input logic                        clk,               // System clock
	input logic                        reset,             // Sync reset
	input logic [7:0]                  reg_addr,          // Offset
	input logic [7:0]                  reg_wdata,         // Write data
	input logic                        reg_wr,            // Write strobe
	input logic                        timer2_overflow,   // Timer-2 pulse
	input logic                        timer0_overflow,   // Timer-0 pulse
	input ppm_pkg::ppm_port_ctrl_t     port1_ctrl,        // Port-1 pads
	input ppm_pkg::ppm_port_ctrl_t     port3_ctrl,        // Port-3 pads
	input logic [7:0]                  port0_strong_sink, // Port-0 sink
	input logic [1:0]                  port2_strong_sink, // Port-2 sink
	input ppm_pkg::ppm_twowire_route_t twowire_route      // Pin pair
);
	// ==========================================================
	// Overflow count mirror, cleared while disabled so restarts line up
	logic [4:0] t0_cnt_ff;
	logic       opt_wr;
	assign opt_wr = reg_wr && reg_addr == 8'h00_a6;
	always_ff @(posedge clk) begin
		if (reset || !port3_ctrl.alt_out_en[4])
			t0_cnt_ff <= 5'h00;
		else if (timer0_overflow)
			t0_cnt_ff <= t0_cnt_ff + 5'h01;
	end

	// ==========================================================
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_p1_low; reg_wr && reg_addr == 8'h00_a2 |=> port1_ctrl.mode[3:0] == $past(reg_wdata); endproperty
	a_p1_low: assert property (p_p1_low) else $error("port-1 low modes");
	property p_p3_high; reg_wr && reg_addr == 8'h00_a5 |=> port3_ctrl.mode[7:4] == $past(reg_wdata); endproperty
	a_p3_high: assert property (p_p3_high) else $error("port-3 high modes");
	property p_p1_an; port1_ctrl.analog[7:6] == 2'h0 && port1_ctrl.analog[5] == (port1_ctrl.mode[5] == 2'h3); endproperty
	a_p1_an: assert property (p_p1_an) else $error("port-1 analog");
	property p_p3_an; port3_ctrl.analog[7:4] == 4'h0 && port3_ctrl.analog[3] == (port3_ctrl.mode[3] == 2'h3); endproperty
	a_p3_an: assert property (p_p3_an) else $error("port-3 analog");
	property p_pair; opt_wr |=> twowire_route == {$past(reg_wdata[6]), !$past(reg_wdata[6])}; endproperty
	a_pair: assert property (p_pair) else $error("pin pair routing");
	property p_half; port1_ctrl.alt_out_en[4] ##1 port1_ctrl.alt_out_en[4] |-> $changed(port1_ctrl.alt_out[4]); endproperty
	a_half: assert property (p_half) else $error("clock half output");
	property p_t2; port1_ctrl.alt_out_en[0] ##1 port1_ctrl.alt_out_en[0]
		|-> port1_ctrl.alt_out[0] == ($past(port1_ctrl.alt_out[0]) ^ $past(timer2_overflow)); endproperty
	a_t2: assert property (p_t2) else $error("timer-2 output");
	property p_t0; port3_ctrl.alt_out_en[4] ##1 port3_ctrl.alt_out_en[4] |-> port3_ctrl.alt_out[4]
		== ($past(port3_ctrl.alt_out[4]) ^ ($past(timer0_overflow) && $past(t0_cnt_ff) == 5'h1f)); endproperty
	a_t0: assert property (p_t0) else $error("timer-0 output");
	property p_t0_rest; !port3_ctrl.alt_out_en[4] ##1 !port3_ctrl.alt_out_en[4] |-> !port3_ctrl.alt_out[4]; endproperty
	a_t0_rest: assert property (p_t0_rest) else $error("timer-0 output not resting");
	property p_sink1; opt_wr |=> port1_ctrl.strong_sink == {8{$past(reg_wdata[3])}}; endproperty
	a_sink1: assert property (p_sink1) else $error("group 2 sink");
	property p_sink0; opt_wr |=> port0_strong_sink == {{4{$past(reg_wdata[2])}}, {4{$past(reg_wdata[1])}}}
		&& port3_ctrl.strong_sink == {{4{$past(reg_wdata[1])}}, {4{$past(reg_wdata[2])}}}
		&& port2_strong_sink == {2{$past(reg_wdata[1])}}; endproperty
	a_sink0: assert property (p_sink0) else $error("group 0 or 1 sink");
endmodule

bind ppm_pin_mux ppm_pin_mux_chk chk_u (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .timer2_overflow(timer2_overflow), .timer0_overflow(timer0_overflow), .port1_ctrl(port1_ctrl),
	.port3_ctrl(port3_ctrl), .port0_strong_sink(port0_strong_sink), .port2_strong_sink(port2_strong_sink),
	.twowire_route(twowire_route));

// ---- bench/ppm_pin_mux_tb.sv ----
/* Self-checking bench for ppm_pin_mux: register port, timer pulses, pads.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps

module ppm_pin_mux_tb;
	logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, timer2_overflow = 0, timer0_overflow = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, port0_strong_sink;
	logic [1:0] port2_strong_sink;
	ppm_pkg::ppm_port_ctrl_t port1_ctrl, port3_ctrl;
	ppm_pkg::ppm_twowire_route_t twowire_route;
	int n_fail = 0, n_tests = 0;

	ppm_pin_mux dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer2_overflow(timer2_overflow), .timer0_overflow(timer0_overflow),
		.port1_ctrl(port1_ctrl), .port3_ctrl(port3_ctrl), .port0_strong_sink(port0_strong_sink),
		.port2_strong_sink(port2_strong_sink), .twowire_route(twowire_route));

	// ==========================================================
	// Clock, compare, bus tasks; checks wait 1 ns so edge updates land
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check("read data", reg_rdata, exp);
	endtask
	task automatic pulse2();
		@(posedge clk);
		timer2_overflow <= 1'b1;
		@(posedge clk);
		timer2_overflow <= 1'b0;
		#1;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		check("p1 modes", port1_ctrl.mode, 16'h5555);
		check("p3 modes", port3_ctrl.mode, 16'h1555);
		check("pair", twowire_route, 2'h1);
		rd(ppm_pkg::ppm_off_p1_high, 8'h55);
		// Read data must fall back to zero after its one answer cycle
		@(posedge clk);
		#1;
		check("read idle", reg_rdata, 8'h00);
		rd(ppm_pkg::ppm_off_p3_high, 8'h15);
		rd(ppm_pkg::ppm_off_pinopt, 8'h00);
	endtask
	task automatic t_modes();
		logic [7:0] v;
		for (int c = 0; c < 4; c++) begin
			v = {4{c[1:0]}};
			wr(ppm_pkg::ppm_off_p1_low, v);
			wr(ppm_pkg::ppm_off_p1_high, v);
			wr(ppm_pkg::ppm_off_p3_low, v);
			wr(ppm_pkg::ppm_off_p3_high, v);
			rd(ppm_pkg::ppm_off_p3_low, v);
			check("p1 modes", port1_ctrl.mode, {2{v}});
			check("p3 modes", port3_ctrl.mode, {2{v}});
			check("p1 analog", port1_ctrl.analog, c == 3 ? 8'h3f : 8'h00);
			check("p3 analog", port3_ctrl.analog, c == 3 ? 8'h0f : 8'h00);
		end
		// Unmapped offset: write ignored, so the all-ones modes must survive
		wr(8'h00_a7, 8'h00);
		rd(8'h00_a7, 8'h00);
		check("p1 modes kept", port1_ctrl.mode, 16'hffff);
		check("p3 modes kept", port3_ctrl.mode, 16'hffff);
	endtask
	task automatic t_option();
		logic [7:0] v;
		for (int i = 0; i < 3; i++) begin
			v = i == 0 ? 8'hc8 : i == 1 ? 8'h04 : 8'h02;
			wr(ppm_pkg::ppm_off_pinopt, v);
			rd(ppm_pkg::ppm_off_pinopt, v & 8'h7f);
			check("pair", twowire_route, {v[6], ~v[6]});
			check("p1 sink", port1_ctrl.strong_sink, {8{v[3]}});
			check("p0 sink", port0_strong_sink, {{4{v[2]}}, {4{v[1]}}});
			check("p3 sink", port3_ctrl.strong_sink, {{4{v[1]}}, {4{v[2]}}});
			check("p2 sink", port2_strong_sink, {2{v[1]}});
		end
	endtask
	task automatic t_outputs();
		wr(ppm_pkg::ppm_off_pinopt, 8'h20);
		check("clk en", port1_ctrl.alt_out_en, 8'h10);
		for (int i = 0; i < 4; i++) begin
			check("clk half", port1_ctrl.alt_out[4], i[0]);
			@(posedge clk);
			#1;
		end
		wr(ppm_pkg::ppm_off_pinopt, 8'h10);
		check("t2 en", port1_ctrl.alt_out_en, 8'h01);
		for (int i = 1; i <= 3; i++) begin
			pulse2();
			check("t2 out", port1_ctrl.alt_out[0], i[0]);
		end
		// Two full half-periods of the divide by 64, pulses back to back
		wr(ppm_pkg::ppm_off_pinopt, 8'h01);
		check("t0 en", port3_ctrl.alt_out_en, 8'h10);
		for (int k = 1; k <= 2; k++) begin
			@(posedge clk);
			timer0_overflow <= 1'b1;
			repeat (31) @(posedge clk);
			#1;
			check("t0 hold", port3_ctrl.alt_out[4], !k[0]);
			@(posedge clk);
			timer0_overflow <= 1'b0;
			#1;
			check("t0 toggle", port3_ctrl.alt_out[4], k[0]);
		end
	endtask

	// ==========================================================
	// Sequence, watchdog and verdict
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		#1;
		t_reset();
		t_modes();
		t_option();
		t_outputs();
		wrap_up();
	end
	initial begin
		repeat (3000) @(posedge clk);
		n_fail++;
		wrap_up();
	end
endmodule

// ---- rtl/ppm_pin_mux.sv ----
/*
 * Pin mode registers and output mux for ports 1 and 3, plus high-sink
 * group enables and divided clock / timer overflow outputs.
 * Assumes one clock, synchronous inputs and timer overflow pulses one
 * cycle wide on the same clock.
 */
// The implementer's own choice: strobed register access.
// What this block does
// - Every port-1 pin has a two-bit mode field choosing modes zero to three, reset to 01.
// - Mode three on port-1 pins 0 to 5 routes the pin to the ADC; pins 6 and 7 get no analog path.
// - Port-3 pins 0 to 3 have two-bit mode fields reset to 01 and mode three routes them to the ADC.
// - Port-3 pins 4 to 7 have two-bit mode fields with no analog option; pins 4 to 6 reset to 01, pin 7 to 00.
// - The two-wire pin select puts clock and data on port-3 pins 4/5 when clear and pins 0/1 when set.
// - Option bit 5 drives the system clock divided by two onto port-1 pin 4.
// - Option bit 4 drives the timer-2 overflow rate divided by two onto port-1 pin 0.
// - Option bit 0 drives the timer-0 overflow rate divided by sixty-four onto port-3 pin 4.
// - Option bit 3 enables high sink on port-1 pins 0 to 7.
// - Option bit 2 enables high sink on port-0 pins 4 to 7 and port-3 pins 0 to 3.
// - Option bit 1 enables high sink on port-0 pins 0 to 3, port-2 pins 0 and 1 and port-3 pins 4 to 7.
`timescale 1ns/1ps

module ppm_pin_mux (
	input  wire logic                         clk,             // 25 MHz system clock
	input  wire logic                         reset,           // Synchronous, active high
	input  wire logic [7:0]                   reg_addr,        // Register offset
	input  wire logic [7:0]                   reg_wdata,       // Write data
	input  wire logic                         reg_wr,          // Write strobe
	input  wire logic                         reg_rd,          // Read strobe
	output logic      [7:0]                   reg_rdata,       // Read data, cycle after strobe
	input  wire logic                         timer2_overflow, // Timer-2 overflow pulse
	input  wire logic                         timer0_overflow, // Timer-0 overflow pulse
	output ppm_pkg::ppm_port_ctrl_t           port1_ctrl,      // Port-1 pad controls
	output ppm_pkg::ppm_port_ctrl_t           port3_ctrl,      // Port-3 pad controls
	output logic      [7:0]                   port0_strong_sink, // Port-0 high sink
	output logic      [1:0]                   port2_strong_sink, // Port-2 pins 0/1 high sink
	output ppm_pkg::ppm_twowire_route_t       twowire_route    // Two-wire pin routing
);

	// ==========================================================
	// Configuration registers
	ppm_pkg::ppm_port_modes_t port1_modes_ff;
	ppm_pkg::ppm_port_modes_t port3_modes_ff;
	logic [7:0]               pin_option_ff;
	logic [7:0]               reg_rdata_ff;

	// Option bit views
	logic twowire_pin_pair_select;
	logic sysclk_half_out_enable;
	logic timer2_toggle_out_enable;
	logic timer0_div64_out_enable;
	logic group0_strong_sink_enable;
	logic group1_strong_sink_enable;
	logic group2_strong_sink_enable;

	// Divided outputs
	logic       sysclk_half_output_ff;
	logic       timer2_toggle_output_ff;
	logic       timer0_div64_output_ff;
	logic [5:0] timer0_count_ff;

	// Analog decode per pin
	function automatic logic is_analog(input logic [1:0] code);
		is_analog = (code == ppm_pkg::ppm_mode_analog);
	endfunction

	// ==========================================================
	// Register writes
	// Port-1 modes, all fields reset to Mode1
	always_ff @(posedge clk) begin
		if (reset) begin
			port1_modes_ff <= {ppm_pkg::ppm_rst_p1_high, ppm_pkg::ppm_rst_p1_low};
		end else if (reg_wr && reg_addr == ppm_pkg::ppm_off_p1_low) begin
			port1_modes_ff[3:0] <= reg_wdata;
		end else if (reg_wr && reg_addr == ppm_pkg::ppm_off_p1_high) begin
			port1_modes_ff[7:4] <= reg_wdata;
		end
	end

	// Port-3 modes; pin 7 alone resets to Mode0
	always_ff @(posedge clk) begin
		if (reset) begin
			port3_modes_ff <= {ppm_pkg::ppm_rst_p3_high, ppm_pkg::ppm_rst_p3_low};
		end else if (reg_wr && reg_addr == ppm_pkg::ppm_off_p3_low) begin
			port3_modes_ff[3:0] <= reg_wdata;
		end else if (reg_wr && reg_addr == ppm_pkg::ppm_off_p3_high) begin
			port3_modes_ff[7:4] <= reg_wdata;
		end
	end

	// Pin option register; bit 7 is unused and holds zero
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_option_ff <= ppm_pkg::ppm_rst_pinopt;
		end else if (reg_wr && reg_addr == ppm_pkg::ppm_off_pinopt) begin
			pin_option_ff <= reg_wdata & ppm_pkg::ppm_pinopt_mask;
		end
	end

	// ==========================================================
	// Register reads, data valid in the next cycle only
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata_ff <= 8'h00_00;
		end else if (reg_rd) begin
			if (reg_addr == ppm_pkg::ppm_off_p1_low) begin
				reg_rdata_ff <= port1_modes_ff[3:0];
			end else if (reg_addr == ppm_pkg::ppm_off_p1_high) begin
				reg_rdata_ff <= port1_modes_ff[7:4];
			end else if (reg_addr == ppm_pkg::ppm_off_p3_low) begin
				reg_rdata_ff <= port3_modes_ff[3:0];
			end else if (reg_addr == ppm_pkg::ppm_off_p3_high) begin
				reg_rdata_ff <= port3_modes_ff[7:4];
			end else if (reg_addr == ppm_pkg::ppm_off_pinopt) begin
				reg_rdata_ff <= pin_option_ff;
			end else begin
				reg_rdata_ff <= 8'h00_00; // Unmapped reads as zero
			end
		end else begin
			reg_rdata_ff <= 8'h00_00; // Zero outside the answer cycle
		end
	end
	assign reg_rdata = reg_rdata_ff;

	// ==========================================================
	// Option bit views
	assign twowire_pin_pair_select   = pin_option_ff[ppm_pkg::ppm_bit_twowire_sel];
	assign sysclk_half_out_enable    = pin_option_ff[ppm_pkg::ppm_bit_clk_half_oe];
	assign timer2_toggle_out_enable  = pin_option_ff[ppm_pkg::ppm_bit_t2_oe];
	assign timer0_div64_out_enable   = pin_option_ff[ppm_pkg::ppm_bit_t0_oe];
	assign group0_strong_sink_enable = pin_option_ff[ppm_pkg::ppm_bit_sink_grp0];
	assign group1_strong_sink_enable = pin_option_ff[ppm_pkg::ppm_bit_sink_grp1];
	assign group2_strong_sink_enable = pin_option_ff[ppm_pkg::ppm_bit_sink_grp2];

	// ==========================================================
	// Divided outputs
	// System clock halved: toggles every cycle while enabled, rests low otherwise
	always_ff @(posedge clk) begin
		if (reset || !sysclk_half_out_enable) begin
			sysclk_half_output_ff <= 1'b0;
		end else begin
			sysclk_half_output_ff <= ~sysclk_half_output_ff;
		end
	end

	// Timer-2 overflow halved by toggling on each overflow
	always_ff @(posedge clk) begin
		if (reset || !timer2_toggle_out_enable) begin
			timer2_toggle_output_ff <= 1'b0;
		end else if (timer2_overflow) begin
			timer2_toggle_output_ff <= ~timer2_toggle_output_ff;
		end
	end

	// Timer-0 overflow by 64: toggle every 32 overflows gives a full period of 64
	always_ff @(posedge clk) begin
		if (reset || !timer0_div64_out_enable) begin
			timer0_count_ff        <= 6'h00;
			timer0_div64_output_ff <= 1'b0;
		end else if (timer0_overflow) begin
			timer0_count_ff <= timer0_count_ff + 6'h01;
			timer0_div64_output_ff <= timer0_count_ff[4:0] == ppm_pkg::ppm_t0_div_last[4:0]
				? ~timer0_div64_output_ff : timer0_div64_output_ff;
		end
	end

	// ==========================================================
	// Per-pin mode and analog routing
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			// Mode code passed straight to pads
			assign port1_ctrl.mode[gi] = port1_modes_ff[gi];
			assign port3_ctrl.mode[gi] = port3_modes_ff[gi];
			// Only the low pins of each port have an ADC path
			assign port1_ctrl.analog[gi] = (gi < ppm_pkg::ppm_p1_analog_pins)
				&& is_analog(port1_modes_ff[gi]);
			assign port3_ctrl.analog[gi] = (gi < ppm_pkg::ppm_p3_analog_pins)
				&& is_analog(port3_modes_ff[gi]);
		end
	endgenerate

	// ==========================================================
	// High-sink groups
	assign port1_ctrl.strong_sink = {8{group2_strong_sink_enable}};
	assign port3_ctrl.strong_sink = {{4{group0_strong_sink_enable}},
		{4{group1_strong_sink_enable}}};
	assign port0_strong_sink = {{4{group1_strong_sink_enable}},
		{4{group0_strong_sink_enable}}};
	assign port2_strong_sink = {2{group0_strong_sink_enable}};

	// ==========================================================
	// Alternate outputs onto fixed pins
	// Built in local vectors so no struct field mixes process and assign drivers
	logic [7:0] p1_alt_en;
	logic [7:0] p1_alt_val;
	logic [7:0] p3_alt_en;
	logic [7:0] p3_alt_val;

	always_comb begin
		p1_alt_en  = 8'h00_00;
		p1_alt_val = 8'h00_00;
		p1_alt_en[ppm_pkg::ppm_p1_pin_t2]   = timer2_toggle_out_enable;
		p1_alt_val[ppm_pkg::ppm_p1_pin_t2]  = timer2_toggle_output_ff;
		p1_alt_en[ppm_pkg::ppm_p1_pin_clk]  = sysclk_half_out_enable;
		p1_alt_val[ppm_pkg::ppm_p1_pin_clk] = sysclk_half_output_ff;
	end

	always_comb begin
		p3_alt_en  = 8'h00_00;
		p3_alt_val = 8'h00_00;
		p3_alt_en[ppm_pkg::ppm_p3_pin_t0]  = timer0_div64_out_enable;
		p3_alt_val[ppm_pkg::ppm_p3_pin_t0] = timer0_div64_output_ff;
	end

	// Hand the vectors to the pad structs
	assign port1_ctrl.alt_out_en = p1_alt_en;
	assign port1_ctrl.alt_out    = p1_alt_val;
	assign port3_ctrl.alt_out_en = p3_alt_en;
	assign port3_ctrl.alt_out    = p3_alt_val;

	// Two-wire pair routing; exactly one pair is active
	assign twowire_route.on_p3_pins_0_1 = twowire_pin_pair_select;
	assign twowire_route.on_p3_pins_4_5 = ~twowire_pin_pair_select;

endmodule

// ---- rtl/ppm_pkg.sv ----
/*
 * Package for the port pin mode and output mux block: register offsets,
 * field positions, reset values, mode codes and carrier structs.
 * Assumes an 8-bit register port with byte offsets as printed.
 */
package ppm_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ppm_off_p1_low  = 8'h00_a2;
	localparam logic [7:0] ppm_off_p1_high = 8'h00_a3;
	localparam logic [7:0] ppm_off_p3_low  = 8'h00_a4;
	localparam logic [7:0] ppm_off_p3_high = 8'h00_a5;
	localparam logic [7:0] ppm_off_pinopt  = 8'h00_a6;

	// ==========================================================
	// Reset values
	localparam logic [7:0] ppm_rst_p1_low  = 8'h00_55;
	localparam logic [7:0] ppm_rst_p1_high = 8'h00_55;
	localparam logic [7:0] ppm_rst_p3_low  = 8'h00_55;
	localparam logic [7:0] ppm_rst_p3_high = 8'h00_15;
	localparam logic [7:0] ppm_rst_pinopt  = 8'h00_00;

	// ==========================================================
	// Pin option field positions
	localparam int ppm_bit_twowire_sel = 6;
	localparam int ppm_bit_clk_half_oe = 5;
	localparam int ppm_bit_t2_oe       = 4;
	localparam int ppm_bit_sink_grp2   = 3;
	localparam int ppm_bit_sink_grp1   = 2;
	localparam int ppm_bit_sink_grp0   = 1;
	localparam int ppm_bit_t0_oe       = 0;
	localparam logic [7:0] ppm_pinopt_mask = 8'h00_7f;

	// ==========================================================
	// Mode codes and divider figures
	localparam logic [1:0] ppm_mode_analog = 2'h3;
	localparam int         ppm_p1_analog_pins = 6;
	localparam int         ppm_p3_analog_pins = 4;
	localparam logic [5:0] ppm_t0_div_last = 6'h3f; // Divide by 64
	localparam int         ppm_p1_pin_t2   = 0;
	localparam int         ppm_p1_pin_clk  = 4;
	localparam int         ppm_p3_pin_t0   = 4;

	// Pin modes, one two-bit code per pin
	typedef logic [7:0][1:0] ppm_port_modes_t;

	// Pad controls of one 8-bit port
	typedef struct packed {
		logic [7:0][1:0] mode;        // Stored mode code per pin, passed through undecoded
		logic [7:0]      analog;      // Pin routed to ADC
		logic [7:0]      strong_sink; // High-sink drive
		logic [7:0]      alt_out_en;  // Alternate output selected
		logic [7:0]      alt_out;     // Alternate output value
	} ppm_port_ctrl_t;

	// Two-wire pin routing
	typedef struct packed {
		logic on_p3_pins_0_1; // Pair on port-3 pins 0/1
		logic on_p3_pins_4_5; // Pair on port-3 pins 4/5
	} ppm_twowire_route_t;

endpackage
